// ==== tb/bus_responder.sv ====
// Far-side peripheral answering external bus cycles
`timescale 1ns/1ns
module bus_responder (
	input  wire        clk_sys,
	input  wire        addrStrobe_n,
	input  wire [1:0]  mode,
	output reg         sizeAck_n,
	output reg         busFault_n,
	output reg         halt_n,
	output reg  [15:0] rdData
);
	initial begin
		sizeAck_n = 1'b1;
		busFault_n = 1'b1;
		halt_n = 1'b1;
		rdData = 16'h0000;
	end
	// Mode 0 ack, 1 error, 2 ack with halt, 3 silent
	always @(posedge clk_sys) begin
		sizeAck_n <= !(!addrStrobe_n && !mode[0]);
		busFault_n <= !(!addrStrobe_n && mode == 2'h1);
		halt_n <= !(!addrStrobe_n && mode == 2'h2);
		rdData <= addrStrobe_n ? ~rdData : 16'h5a3c;
	end
endmodule // bus_responder

// ==== tb/bus_termination_exception_monitor.sv ====
// Checker for the bus termination and exception block
`timescale 1ns/1ns
module bus_termination_exception_monitor (
	input wire        clk_sys,
	input wire        rst_n,
	input wire        cycleIsPrefetch,
	input wire        internalAck,
	input wire [2:0]  irqMaskLevel,
	input wire [2:0]  pendingIrqLevel,
	input wire        monitorEnable,
	input wire [1:0]  monitorTimeoutSel,
	input wire        cycleDone,
	input wire [1:0]  cycleOutcome,
	input wire [15:0] cycleRdData,
	input wire        doubleBusFault,
	input wire        lowPowerStopped,
	input wire [2:0]  clockCtrlMask,
	input wire        sizeAckIn_n,
	input wire        autovectorReqIn_n,
	input wire [19:0] addrOut,
	input wire [2:0]  functionCode,
	input wire [15:0] dataOut,
	input wire        dataOe,
	input wire        addrStrobe_n,
	input wire        dataStrobe_n,
	input wire        haltOut,
	input wire        haltOe
);
	reg  [7:0] ackAge;
	reg  [7:0] lowCnt;
	wire       bcastAddr = addrOut == 20'h3fffe && functionCode == 3'h7;
	wire       bcast     = !addrStrobe_n && bcastAddr;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// Age of last acknowledge, strobe length
	// ----------------------------------------
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ackAge <= 8'hff;
			lowCnt <= 8'h00;
		end else begin
			ackAge <= (!sizeAckIn_n || !autovectorReqIn_n || internalAck) ? 8'h00 : ackAge + {7'h00, ackAge != 8'hff};
			lowCnt <= addrStrobe_n ? 8'h00 : lowCnt + 8'h01;
		end
	end
	a_bcast_data: assert property (bcast |-> dataOut[15:3] == 13'h0000) else $error("stop data high bits set");
	a_bcast_ack: assert property ($fell(addrStrobe_n) && bcast |=> cycleDone && cycleOutcome == 2'h1)
		else $error("stop cycle not self acknowledged");
	a_stop_mask: assert property ($fell(addrStrobe_n) && bcast |-> ##2 lowPowerStopped
		&& clockCtrlMask == $past(dataOut[2:0], 2)) else $error("mask copy wrong");
	a_stop_wake: assert property (lowPowerStopped && pendingIrqLevel > irqMaskLevel |-> ##[1:4] !lowPowerStopped)
		else $error("stop not left");
	a_ack_cause: assert property (cycleDone && cycleOutcome != 2'h3 && !bcastAddr |-> ackAge <= 8'h08)
		else $error("normal end without acknowledge");
	a_monitor_bound: assert property (monitorEnable |-> lowCnt <= (8'h40 >> monitorTimeoutSel) + 8'h08)
		else $error("monitor did not end cycle");
	a_fault_halt: assert property (doubleBusFault |=> doubleBusFault && haltOe && !haltOut)
		else $error("double fault not halting");
	a_prefetch_ff: assert property (cycleDone && cycleOutcome == 2'h3 && cycleIsPrefetch |-> ##[0:1] cycleRdData == 16'hffff)
		else $error("prefetch error data wrong");
	a_halt_float: assert property (cycleDone && cycleOutcome == 2'h2 |-> addrStrobe_n && dataStrobe_n && !dataOe
		##1 $stable(addrOut)) else $error("halted bus not floated");
endmodule // bus_termination_exception_monitor

// ==== tb/bus_termination_exception_tb_top.sv ====
// Testbench for the bus termination and exception block
`timescale 1ns/1ns
module bus_termination_exception_tb_top;
	reg         clk_sys, rst_n, cycleReq, cycleIsPrefetch, lowPowerStopInstr, instrBoundary, handlerFirstInstr;
	reg         iack, intAck, granted, arbHit, avecN, monitorEnable;
	reg  [2:0]  irqMaskLevel, pendingIrqLevel;
	reg  [1:0]  mode, tmoSel;
	wire        ackN, faultN, haltN, cycleDone, errPend, errExc, dbf, stopped, haltOe, asN, rw;
	wire [1:0]  outcome, tsize;
	wire [2:0]  mask;
	wire [15:0] rdData, pinData;
	integer     fail_count, checks, lastWait;
	bus_termination_exception dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .cycleReq(cycleReq),
		.cycleAddr(20'h01234), .cycleFc(3'h5), .cycleSize(2'h2), .cycleRead(1'b1), .cycleWrData(16'h0000),
		.cycleIsPrefetch(cycleIsPrefetch), .cycleIsIack(iack), .internalAck(intAck),
		.lowPowerStopInstr(lowPowerStopInstr), .irqMaskLevel(irqMaskLevel), .pendingIrqLevel(pendingIrqLevel),
		.instrBoundary(instrBoundary), .handlerFirstInstr(handlerFirstInstr), .busGranted(granted),
		.monitorEnable(monitorEnable), .monitorTimeoutSel(tmoSel), .irqArbContention(arbHit), .cycleDone(cycleDone),
		.cycleOutcome(outcome), .cycleRdData(rdData), .busErrorPending(errPend), .busErrorException(errExc),
		.doubleBusFault(dbf), .lowPowerStopped(stopped), .clockCtrlMask(mask), .sizeAckIn_n(ackN),
		.autovectorReqIn_n(avecN), .busFaultIn_n(faultN), .haltIn_n(haltN), .dataIn(pinData), .addrOut(),
		.functionCode(), .transferSize(tsize), .readWrite(rw), .dataOut(), .dataOe(), .addrStrobe_n(asN),
		.dataStrobe_n(), .haltOut(), .haltOe(haltOe));
	bus_responder resp_u (.clk_sys(clk_sys), .addrStrobe_n(asN), .mode(mode),
		.sizeAck_n(ackN), .busFault_n(faultN), .halt_n(haltN), .rdData(pinData));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task chk(input [15:0] got, input [15:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("mismatch at %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task end_of_test;
		begin
			$display("checks %0d mismatches %0d", checks, fail_count);
			if (fail_count == 0 && checks > 0) $display("All checks passed");
			else $display("Checks failed");
			$finish;
		end
	endtask
	// One-cycle strobe: 0 instruction boundary, 1 first handler instruction
	task pulse(input which);
		begin
			if (which)
				handlerFirstInstr = 1'b1;
			else
				instrBoundary = 1'b1;
			@(negedge clk_sys) {instrBoundary, handlerFirstInstr} = 2'h0;
			repeat (2) @(negedge clk_sys);
		end
	endtask
	task do_reset;
		begin
			rst_n = 1'b0;
			repeat (3) @(negedge clk_sys);
			rst_n = 1'b1;
		end
	endtask
	task cyc(input [1:0] m, input p, input [1:0] exp);
		integer i;
		begin
			mode = m;
			cycleIsPrefetch = p;
			cycleReq = 1'b1;
			@(negedge clk_sys) cycleReq = 1'b0;
			for (i = 0; i < 200 && cycleDone !== 1'b1; i = i + 1) @(negedge clk_sys);
			lastWait = i;
			chk(outcome, exp);
			@(negedge clk_sys);
			repeat (6) @(negedge clk_sys);
		end
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_fault_after_reset;
		begin
			cyc(2'h1, 1'b0, 2'h3);
			chk(dbf, 1'b1);
			chk(haltOe, 1'b1);
			do_reset;
			chk(dbf, 1'b0);
			$display("fault after reset done");
		end
	endtask
	task t_terminations;
		begin
			pulse(1'b0);
			cyc(2'h0, 1'b0, 2'h1);
			chk(rdData, 16'h5a3c);
			cyc(2'h2, 1'b0, 2'h2);
			chk({rw, tsize}, 3'h6);
			cyc(2'h1, 1'b1, 2'h3);
			chk(rdData, 16'hffff);
			cyc(2'h3, 1'b0, 2'h3);
			chk(errPend, 1'b1);
			chk(errExc, 1'b0);
			chk(dbf, 1'b0);
			$display("terminations done");
		end
	endtask
	task t_exception;
		integer i;
		begin
			instrBoundary = 1'b1;
			for (i = 0; i < 4 && errExc !== 1'b1; i = i + 1) @(negedge clk_sys);
			instrBoundary = 1'b0;
			chk(errExc, 1'b1);
			pulse(1'b1);
			chk(errPend, 1'b0);
			cyc(2'h1, 1'b0, 2'h3);
			chk(dbf, 1'b0);
			$display("exception done");
		end
	endtask
	task t_alt_ends;
		begin
			iack = 1'b1;
			cyc(2'h0, 1'b0, 2'h3);
			arbHit = 1'b1;
			cyc(2'h0, 1'b0, 2'h1);
			{iack, arbHit, intAck} = 3'h1;
			cyc(2'h3, 1'b0, 2'h1);
			{intAck, avecN} = 2'h0;
			cyc(2'h3, 1'b0, 2'h1);
			avecN = 1'b1;
			tmoSel = 2'h2;
			repeat (3) @(negedge clk_sys);
			cyc(2'h3, 1'b0, 2'h3);
			chk(lastWait, 16'h0011);
			tmoSel = 2'h3;
			$display("alternate ends done");
		end
	endtask
	task stop_once(input [2:0] m, input g);
		begin
			granted = g;
			irqMaskLevel = m;
			pendingIrqLevel = m;
			lowPowerStopInstr = 1'b1;
			@(negedge clk_sys) lowPowerStopInstr = 1'b0;
			chk(asN, g);
			repeat (3) @(negedge clk_sys);
			chk(stopped, 1'b1);
			chk(mask, m);
			pendingIrqLevel = m + 3'h1;
			repeat (4) @(negedge clk_sys);
			chk(stopped, 1'b0);
			granted = 1'b0;
		end
	endtask
	task t_stop;
		begin
			stop_once(3'h5, 1'b0);
			stop_once(3'h2, 1'b1);
			$display("stop done");
		end
	endtask
	task t_entry_fault;
		integer i;
		begin
			instrBoundary = 1'b1;
			for (i = 0; i < 4 && errExc !== 1'b1; i = i + 1) @(negedge clk_sys);
			instrBoundary = 1'b0;
			chk(errExc, 1'b1);
			cyc(2'h1, 1'b0, 2'h3);
			chk(dbf, 1'b1);
			chk(haltOe, 1'b1);
			do_reset;
			$display("entry fault done");
		end
	endtask
	initial begin
		fail_count = 0;
		checks = 0;
		{rst_n, cycleReq, cycleIsPrefetch, lowPowerStopInstr, instrBoundary, handlerFirstInstr} = 6'h00;
		{iack, intAck, granted, arbHit} = 4'h0;
		{avecN, tmoSel, monitorEnable, irqMaskLevel, pendingIrqLevel, mode} = 12'hf00;
		do_reset;
		t_fault_after_reset;
		t_terminations;
		t_exception;
		t_alt_ends;
		t_stop;
		t_entry_fault;
		end_of_test;
	end
	initial begin
		#100000;
		fail_count = fail_count + 1;
		end_of_test;
	end
endmodule // bus_termination_exception_tb_top
bind bus_termination_exception bus_termination_exception_monitor mon_u (.clk_sys, .rst_n, .cycleIsPrefetch,
	.internalAck, .irqMaskLevel, .pendingIrqLevel, .monitorEnable, .monitorTimeoutSel, .cycleDone,
	.cycleOutcome, .cycleRdData, .doubleBusFault, .lowPowerStopped, .clockCtrlMask, .sizeAckIn_n,
	.autovectorReqIn_n, .addrOut, .functionCode, .dataOut, .dataOe, .addrStrobe_n, .dataStrobe_n,
	.haltOut, .haltOe);

// ==== verilog/bus_monitor.v ====
// Bus monitor: times out unanswered cycles
`timescale 1ns/1ns
`include "bus_termination_exception_consts.vh"
module bus_monitor (
	input  wire       clk_sys,
	input  wire       rst_n,
	input  wire       monitorEnable,
	input  wire [1:0] monitorTimeoutSel,
	input  wire       cycleActive,
	input  wire       terminated,
	output reg        timeoutPulse
);
	reg  [6:0] count_reg;
	reg  [6:0] limit;

	always @* begin
		case (monitorTimeoutSel)
			2'h0:    limit = `MON_PERIOD_0;
			2'h1:    limit = `MON_PERIOD_1;
			2'h2:    limit = `MON_PERIOD_2;
			default: limit = `MON_PERIOD_3;
		endcase
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			count_reg    <= 7'h00;
			timeoutPulse <= 1'b0;
		end else begin
			timeoutPulse <= 1'b0;
			if (!cycleActive || terminated || !monitorEnable) begin
				count_reg <= 7'h00;
			end else if (count_reg == limit - 7'h01) begin
				count_reg    <= 7'h00;
				timeoutPulse <= 1'b1;
			end else begin
				count_reg <= count_reg + 7'h01;
			end
		end
	end
endmodule // bus_monitor

// ==== verilog/bus_termination_exception.v ====
// Bus cycle termination, bus error latch, double fault and stop broadcast
// Operation
// - Stop instruction issues CPU-space write 3FFFE
// - Broadcast data carries mask, upper bits zero
// - Broadcast shown externally only when bus owned
// - Broadcast self-acknowledged with fast write timing
// - Bus error during broadcast is ignored
// - Stop ends on reset or higher interrupt
// - Normal end needs size ack, autovector or internal ack
// - Monitor raises bus error on response timeout
// - No arbitration contention on iack gives error
// - Bus error ends cycle, starts exception
// - Halt input gives single-cycle bus operation
// - Ack at S and S+2 ends normally
// - Ack with halt ends cycle then halts
// - Bus error at S, or with halt later
// - Bus error latched at cycle end, deferred
// - Errored cycle captures no data, prefetch FF
// - Handler clears latch; one exception per instruction
// - Double fault before handler or after reset
// - Double fault halts, drives halt low
// - Errors after the handler's first instruction are ordinary
// - Two-bit monitor select, at most 64 clocks
// - Wait states inserted while nothing terminates
// - Halted: data floats, strobes inactive, address held
`timescale 1ns/1ns
`include "bus_termination_exception_consts.vh"
module bus_termination_exception (
	input  wire        clk_sys,
	input  wire        rst_n,
	// Processor side
	input  wire        cycleReq,
	input  wire [19:0] cycleAddr,
	input  wire [2:0]  cycleFc,
	input  wire [1:0]  cycleSize,
	input  wire        cycleRead,
	input  wire [15:0] cycleWrData,
	input  wire        cycleIsPrefetch,
	input  wire        cycleIsIack,
	input  wire        internalAck,
	input  wire        lowPowerStopInstr,
	input  wire [2:0]  irqMaskLevel,
	input  wire [2:0]  pendingIrqLevel,
	input  wire        instrBoundary,
	input  wire        handlerFirstInstr,
	input  wire        busGranted,
	input  wire        monitorEnable,
	input  wire [1:0]  monitorTimeoutSel,
	input  wire        irqArbContention,
	output reg         cycleDone,
	output reg  [1:0]  cycleOutcome,
	output reg  [15:0] cycleRdData,
	output reg         busErrorPending,
	output reg         busErrorException,
	output reg         doubleBusFault,
	output reg         lowPowerStopped,
	output reg  [2:0]  clockCtrlMask,
	// External bus pins
	input  wire        sizeAckIn_n,
	input  wire        autovectorReqIn_n,
	input  wire        busFaultIn_n,
	input  wire        haltIn_n,
	input  wire [15:0] dataIn,
	output reg  [19:0] addrOut,
	output reg  [2:0]  functionCode,
	output reg  [1:0]  transferSize,
	output reg         readWrite,
	output reg  [15:0] dataOut,
	output reg         dataOe,
	output reg         addrStrobe_n,
	output reg         dataStrobe_n,
	output wire        haltOut,
	output wire        haltOe
);
	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam [2:0] ST_IDLE    = 3'h0;
	localparam [2:0] ST_WAIT    = 3'h1;
	localparam [2:0] ST_CONFIRM = 3'h2;
	localparam [2:0] ST_HALTED  = 3'h3;
	localparam [2:0] ST_BCAST   = 3'h4;
	localparam [2:0] ST_STOPPED = 3'h5;
	localparam [2:0] ST_FAULT   = 3'h6;

	reg  [2:0] state_reg;
	reg  [2:0] state_next;
	reg        ackSeen_reg;
	reg        haltSeen_reg;
	reg        afterReset_reg;
	reg        inEntry_reg;
	reg        cycleErr_reg;
	reg        bcastShown_reg;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	wire [3:0]  pinSync;
	wire [15:0] dataSync;
	wire        monitorTimeout;

	pin_sync #(.WIDTH(4), .INIT(4'hf)) u_ctrlSync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.pinIn   ({sizeAckIn_n, autovectorReqIn_n, busFaultIn_n, haltIn_n}),
		.syncOut (pinSync)
	);

	pin_sync #(.WIDTH(16), .INIT(16'h0000)) u_dataSync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.pinIn   (dataIn),
		.syncOut (dataSync)
	);

	wire extAck    = ~pinSync[3] | ~pinSync[2];
	wire extBerr   = ~pinSync[1];
	wire extHalt   = ~pinSync[0];
	wire inCycle   = (state_reg == ST_WAIT) || (state_reg == ST_CONFIRM);
	wire anyAck    = extAck | internalAck;
	wire spurious  = inCycle && cycleIsIack && anyAck && !irqArbContention;
	wire anyBerr   = extBerr | monitorTimeout | spurious;

	bus_monitor u_monitor (
		.clk_sys           (clk_sys),
		.rst_n             (rst_n),
		.monitorEnable     (monitorEnable),
		.monitorTimeoutSel (monitorTimeoutSel),
		.cycleActive       (inCycle),
		.terminated        (anyAck),
		.timeoutPulse      (monitorTimeout)
	);

	// ----------------------------------------
	// Termination decode
	// ----------------------------------------
	wire bcastStart = (state_reg == ST_IDLE) && lowPowerStopInstr && !doubleBusFault;
	wire wakeUp     = pendingIrqLevel > irqMaskLevel;
	wire errEnd     = inCycle && anyBerr;
	wire okEnd      = (state_reg == ST_CONFIRM) && ackSeen_reg && anyAck && !anyBerr;

	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (doubleBusFault)
					state_next = ST_FAULT;
				else if (bcastStart)
					state_next = ST_BCAST;
				else if (cycleReq)
					state_next = ST_WAIT;
			end
			ST_WAIT: begin
				if (anyBerr)
					state_next = ST_IDLE;
				else if (anyAck)
					state_next = ST_CONFIRM;
			end
			ST_CONFIRM: begin
				if (anyBerr)
					state_next = ST_IDLE;
				else if (!anyAck)
					state_next = ST_WAIT;
				else if (haltSeen_reg && extHalt)
					state_next = ST_HALTED;
				else
					state_next = ST_IDLE;
			end
			ST_HALTED: begin
				if (!extHalt)
					state_next = ST_IDLE;
			end
			ST_BCAST:   state_next = ST_STOPPED;
			ST_STOPPED: begin
				if (wakeUp)
					state_next = ST_IDLE;
			end
			ST_FAULT:   state_next = ST_FAULT;
			default:    state_next = ST_IDLE;
		endcase
	end

	// ----------------------------------------
	// Cycle control and outputs
	// ----------------------------------------
	wire entering   = (state_reg == ST_IDLE) && cycleReq && !bcastStart && !doubleBusFault;
	wire drivePins  = (entering || inCycle) && !busGranted;
	wire errorHit   = errEnd;
	wire secondErr  = errorHit && (inEntry_reg || afterReset_reg) && !busErrorPending;

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg         <= ST_IDLE;
			ackSeen_reg       <= 1'b0;
			haltSeen_reg      <= 1'b0;
			afterReset_reg    <= 1'b1;
			inEntry_reg       <= 1'b0;
			cycleErr_reg      <= 1'b0;
			bcastShown_reg    <= 1'b0;
			cycleDone         <= 1'b0;
			cycleOutcome      <= `TERM_NONE;
			cycleRdData       <= 16'h0000;
			busErrorPending   <= 1'b0;
			busErrorException <= 1'b0;
			doubleBusFault    <= 1'b0;
			lowPowerStopped   <= 1'b0;
			clockCtrlMask     <= 3'h0;
			addrOut           <= 20'h00000;
			functionCode      <= 3'h0;
			transferSize      <= 2'h0;
			readWrite         <= 1'b1;
			dataOut           <= 16'h0000;
			dataOe            <= 1'b0;
			addrStrobe_n      <= 1'b1;
			dataStrobe_n      <= 1'b1;
		end else begin
			state_reg         <= state_next;
			cycleDone         <= 1'b0;
			cycleOutcome      <= `TERM_NONE;
			busErrorException <= 1'b0;
			ackSeen_reg       <= inCycle && anyAck;
			haltSeen_reg      <= (inCycle || entering) && (extHalt || haltSeen_reg);
			if (state_reg == ST_IDLE)
				cycleErr_reg <= 1'b0;
			if (entering) begin
				addrOut      <= cycleAddr;
				functionCode <= cycleFc;
				transferSize <= cycleSize;
				readWrite    <= cycleRead;
				dataOut      <= cycleWrData;
			end
			addrStrobe_n <= !drivePins;
			dataStrobe_n <= !(drivePins && cycleRead);
			dataOe       <= drivePins && !cycleRead;
			if (errEnd) begin
				cycleDone    <= 1'b1;
				cycleOutcome <= `TERM_BUSERR;
				cycleErr_reg <= 1'b1;
				if (cycleIsPrefetch)
					cycleRdData <= {`PRECHARGE_BYTE, `PRECHARGE_BYTE};
				addrStrobe_n <= 1'b1;
				dataStrobe_n <= 1'b1;
				dataOe       <= 1'b0;
			end else if (okEnd) begin
				cycleDone    <= 1'b1;
				cycleOutcome <= (haltSeen_reg && extHalt) ? `TERM_HALT : `TERM_NORMAL;
				if (cycleRead)
					cycleRdData <= dataSync;
				addrStrobe_n <= 1'b1;
				dataStrobe_n <= 1'b1;
				dataOe       <= 1'b0;
			end
			// Broadcast write, self-acknowledged
			if (bcastStart) begin
				bcastShown_reg <= !busGranted;
				clockCtrlMask  <= irqMaskLevel;
				addrOut        <= `LPS_BCAST_ADDR;
				functionCode   <= `CPU_SPACE_FC;
				transferSize   <= 2'h2;
				readWrite      <= 1'b0;
				dataOut        <= {13'h0000, irqMaskLevel};
				addrStrobe_n   <= busGranted;
				dataOe         <= !busGranted;
				dataStrobe_n   <= 1'b1;
			end
			if (state_reg == ST_BCAST) begin
				cycleDone      <= 1'b1;
				cycleOutcome   <= `TERM_NORMAL;
				addrStrobe_n   <= 1'b1;
				dataOe         <= 1'b0;
				bcastShown_reg <= 1'b0;
				lowPowerStopped <= 1'b1;
			end
			if ((state_reg == ST_STOPPED) && wakeUp)
				lowPowerStopped <= 1'b0;
			// Error latch: set wins over the handler's clear
			if (errorHit)
				busErrorPending <= 1'b1;
			else if (handlerFirstInstr)
				busErrorPending <= 1'b0;
			if (instrBoundary && busErrorPending && !inEntry_reg && !afterReset_reg) begin
				busErrorException <= 1'b1;
				inEntry_reg       <= 1'b1;
			end
			if (handlerFirstInstr)
				inEntry_reg <= 1'b0;
			if (instrBoundary || handlerFirstInstr)
				afterReset_reg <= 1'b0;
			if (secondErr || (errorHit && inEntry_reg))
				doubleBusFault <= 1'b1;
			if (doubleBusFault) begin
				addrStrobe_n <= 1'b1;
				dataStrobe_n <= 1'b1;
				dataOe       <= 1'b0;
			end
		end
	end

	assign haltOut = 1'b0;
	assign haltOe  = doubleBusFault;
endmodule // bus_termination_exception

// ==== verilog/bus_termination_exception_consts.vh ====
// Constants for the bus termination and exception block
`ifndef BUS_TERMINATION_EXCEPTION_CONSTS_VH
`define BUS_TERMINATION_EXCEPTION_CONSTS_VH

// ----------------------------------------
// Broadcast cycle encoding
// ----------------------------------------
`define LPS_BCAST_ADDR      20'h3fffe
`define CPU_SPACE_FC        3'h7
`define PRECHARGE_BYTE      8'hff
`define MASK_LSB            0
`define MASK_MSB            2

// ----------------------------------------
// Bus monitor periods in system clocks
// ----------------------------------------
`define MON_PERIOD_0        7'h40
`define MON_PERIOD_1        7'h20
`define MON_PERIOD_2        7'h10
`define MON_PERIOD_3        7'h08

// ----------------------------------------
// Termination outcome codes
// ----------------------------------------
`define TERM_NONE           2'h0
`define TERM_NORMAL         2'h1
`define TERM_HALT           2'h2
`define TERM_BUSERR         2'h3

`endif

// ==== verilog/pin_sync.v ====
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ns
module pin_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
	input  wire             clk_sys,
	input  wire             rst_n,
	input  wire [WIDTH-1:0] pinIn,
	output wire [WIDTH-1:0] syncOut
);
	reg [WIDTH-1:0] stage1_reg;
	reg [WIDTH-1:0] stage2_reg;

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stage1_reg <= INIT;
			stage2_reg <= INIT;
		end else begin
			stage1_reg <= pinIn;
			stage2_reg <= stage1_reg;
		end
	end

	assign syncOut = stage2_reg;
endmodule // pin_sync
